/* hw/egress_cfg_pkg.sv */
/*
  Constants, types and the tag decision function for the egress tagging
  and rate configuration block. Assumes a single system clock at 25 MHz.
*/
`default_nettype none
package egress_cfg_pkg;
  localparam int NUM_PORTS = 3;
  localparam int NUM_QUEUES = 6;
  localparam int PORT_FIELD_W = 8;
  localparam int RATE_W = 13;
  localparam int ELAPSED_W = 14;
  localparam logic [15:0] TAG_RULES_ADDR = 16'h1c0c;
  localparam logic [15:0] RATE_P0_Q01_ADDR = 16'h1c0d;
  localparam logic [15:0] RATE_P0_Q23_ADDR = 16'h1c0e;
  localparam logic [15:0] RATE_P1_Q01_ADDR = 16'h1c0f;
  localparam logic [31:0] TAG_RULES_RESET = 32'h0000_0000;
  localparam logic [31:0] TAG_RULES_MASK = 32'h003f_3f3f;
  localparam logic [RATE_W-1:0] RATE_RESET = 13'h0000;
  localparam int TYPE_LSB = 0;
  localparam int CHG_TAG_BIT = 2;
  localparam int CHG_PRI_BIT = 3;
  localparam int CHG_VID_BIT = 4;
  localparam int INS_TAG_BIT = 5;
  localparam int RATE_LO_LSB = 0;
  localparam int RATE_HI_LSB = 13;
  localparam int RATE_UNIT_NS = 20;
  localparam int CLK_PERIOD_NS = 40;
  localparam logic [ELAPSED_W-1:0] UNITS_PER_CLK =
    ELAPSED_W'(CLK_PERIOD_NS / RATE_UNIT_NS);
  localparam logic [ELAPSED_W-1:0] ELAPSED_CAP = 14'h2000;

  typedef enum logic [1:0] {
    EGR_DUMB, EGR_ACCESS, EGR_HYBRID, EGR_CPU
  } egress_type_e;

  typedef enum logic [1:0] {
    PKT_UNTAGGED, PKT_REGULAR, PKT_PRIORITY, PKT_SPECIAL
  } pkt_class_e;

  typedef struct packed {
    logic strip;
    logic insert;
    logic chg_vid;
    logic chg_pri;
    logic vid_ingress;
    logic add_special;
  } tag_act_s;

  function automatic tag_act_s decode_action(
    input logic [PORT_FIELD_W-1:0] ctl,
    input pkt_class_e cls,
    input logic untag
  );
    tag_act_s act;
    act = '0;
    unique case (egress_type_e'(ctl[TYPE_LSB +: 2]))
      EGR_DUMB: act.strip = (cls == PKT_SPECIAL);
      EGR_ACCESS: act.strip = (cls != PKT_UNTAGGED);
      EGR_HYBRID: begin
        if (cls == PKT_UNTAGGED) begin
          act.insert = ctl[INS_TAG_BIT] && !untag;
        end else if (untag || cls == PKT_SPECIAL) begin
          act.strip = 1'b1;
        end else if (cls == PKT_PRIORITY) begin
          act.vid_ingress = 1'b1;
        end else if (ctl[CHG_TAG_BIT]) begin
          act.chg_vid = ctl[CHG_VID_BIT];
          act.chg_pri = ctl[CHG_PRI_BIT];
        end
      end
      EGR_CPU: act.add_special = 1'b1;
    endcase
    return act;
  endfunction
endpackage
`default_nettype wire

/* hw/egress_cfg_if.sv */
/*
  Configuration carrier from the register bank to the tagger and shaper.
  Assumes all three modules share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface egress_cfg_if;
  logic [egress_cfg_pkg::NUM_PORTS-1:0]
        [egress_cfg_pkg::PORT_FIELD_W-1:0] port_ctl;
  logic [egress_cfg_pkg::NUM_QUEUES-1:0]
        [egress_cfg_pkg::RATE_W-1:0] rate;
  modport regs (output port_ctl, output rate);
  modport tagger (input port_ctl);
  modport shaper (input rate);
endinterface
`default_nettype wire

/* hw/egress_tagger.sv */
/*
  Per-port egress tag action decoder with registered outputs.
  Assumes packet descriptors come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module egress_tagger (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Configuration.
  egress_cfg_if.tagger cfg,
  // Packet descriptors.
  input wire logic [egress_cfg_pkg::NUM_PORTS-1:0] pkt_valid,
  input wire logic [egress_cfg_pkg::NUM_PORTS-1:0][1:0] pkt_class,
  input wire logic [egress_cfg_pkg::NUM_PORTS-1:0] pkt_untag,
  // Tag actions.
  output logic [egress_cfg_pkg::NUM_PORTS-1:0] act_valid_q,
  output egress_cfg_pkg::tag_act_s [egress_cfg_pkg::NUM_PORTS-1:0] act_q
);
  egress_cfg_pkg::tag_act_s [egress_cfg_pkg::NUM_PORTS-1:0] act_d;

  for (genvar p = 0; p < egress_cfg_pkg::NUM_PORTS; p++) begin : g_port
    always_comb begin
      act_d[p] = '0;
      if (pkt_valid[p]) begin
        act_d[p] = egress_cfg_pkg::decode_action(cfg.port_ctl[p],
          egress_cfg_pkg::pkt_class_e'(pkt_class[p]), pkt_untag[p]);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      act_valid_q <= '0;
      act_q <= '0;
    end else begin
      act_valid_q <= pkt_valid;
      act_q <= act_d;
    end
  end
endmodule // egress_tagger
`default_nettype wire

/* hw/egress_shaper.sv */
/*
  Per-queue byte pacer: releases a byte no sooner than the programmed
  interval after the previous one. Assumes requests from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module egress_shaper (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Configuration.
  egress_cfg_if.shaper cfg,
  // Byte requests and releases.
  input wire logic [egress_cfg_pkg::NUM_QUEUES-1:0] byte_req,
  output logic [egress_cfg_pkg::NUM_QUEUES-1:0] byte_grant_q
);
  localparam int EW = egress_cfg_pkg::ELAPSED_W;
  logic [egress_cfg_pkg::NUM_QUEUES-1:0][EW-1:0] elapsed_q;
  logic [egress_cfg_pkg::NUM_QUEUES-1:0][EW-1:0] elapsed_d;
  logic [egress_cfg_pkg::NUM_QUEUES-1:0] grant_d;

  for (genvar q = 0; q < egress_cfg_pkg::NUM_QUEUES; q++) begin : g_q
    logic [EW-1:0] need;
    assign need = {1'b0, cfg.rate[q]} + 14'h0001;
    always_comb begin
      grant_d[q] = byte_req[q] && (elapsed_q[q] >= need);
      if (grant_d[q]) begin
        elapsed_d[q] = '0;
      end else if (elapsed_q[q] < egress_cfg_pkg::ELAPSED_CAP) begin
        elapsed_d[q] = elapsed_q[q] + egress_cfg_pkg::UNITS_PER_CLK;
      end else begin
        elapsed_d[q] = elapsed_q[q];
      end
    end
    // Clocks since the previous release, kept only for the spacing check.
    logic [EW-1:0] gap_q;
    logic [EW-1:0] gap_d;
    always_comb begin
      if (byte_grant_q[q]) begin
        gap_d = 14'h0001;
      end else if (gap_q < egress_cfg_pkg::ELAPSED_CAP) begin
        gap_d = gap_q + 14'h0001;
      end else begin
        gap_d = gap_q;
      end
    end
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        gap_q <= egress_cfg_pkg::ELAPSED_CAP;
      end else begin
        gap_q <= gap_d;
      end
    end
    chk_byte_spacing: assert property (@(posedge clk) disable iff (!rst_b)
      byte_grant_q[q] |-> {gap_q, 1'b0} >= {1'b0, need})
      else $error("Byte released before its interval.");
    chk_release_prompt: assert property (@(posedge clk) disable iff (!rst_b)
      byte_req[q] && elapsed_q[q] >= need |=> byte_grant_q[q])
      else $error("Byte held past its interval.");
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      elapsed_q <= '0;
      byte_grant_q <= '0;
    end else begin
      elapsed_q <= elapsed_d;
      byte_grant_q <= grant_d;
    end
  end
endmodule // egress_shaper
`default_nettype wire

/* hw/egress_tag_rate_config.sv */
/*
  Egress tagging rules and egress rate register bank, with the tag
  decoder and byte shaper that consume them. Assumes a one-cycle register
  port whose strobes are never both high.
*/
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module egress_tag_rate_config (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Register port.
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  // Packet descriptors and tag actions.
  input wire logic [egress_cfg_pkg::NUM_PORTS-1:0] pkt_valid,
  input wire logic [egress_cfg_pkg::NUM_PORTS-1:0][1:0] pkt_class,
  input wire logic [egress_cfg_pkg::NUM_PORTS-1:0] pkt_untag,
  output logic [egress_cfg_pkg::NUM_PORTS-1:0] act_valid_q,
  output egress_cfg_pkg::tag_act_s [egress_cfg_pkg::NUM_PORTS-1:0] act_q,
  // Shaper.
  input wire logic [egress_cfg_pkg::NUM_QUEUES-1:0] byte_req,
  output logic [egress_cfg_pkg::NUM_QUEUES-1:0] byte_grant_q
);
  localparam int RW = egress_cfg_pkg::RATE_W;

  egress_cfg_if cfg ();

  logic [31:0] tag_rules_q;
  logic [31:0] tag_rules_d;
  logic [egress_cfg_pkg::NUM_QUEUES-1:0][RW-1:0] rate_q;
  logic [egress_cfg_pkg::NUM_QUEUES-1:0][RW-1:0] rate_d;
  logic [31:0] reg_rdata_d;

  // Maps a register address to its rate pair index, or 3 when none.
  function automatic logic [1:0] rate_index(input logic [15:0] addr);
    unique case (addr)
      egress_cfg_pkg::RATE_P0_Q01_ADDR: return 2'h0;
      egress_cfg_pkg::RATE_P0_Q23_ADDR: return 2'h1;
      egress_cfg_pkg::RATE_P1_Q01_ADDR: return 2'h2;
      default: return 2'h3;
    endcase
  endfunction

  // Register writes.
  always_comb begin
    tag_rules_d = tag_rules_q;
    rate_d = rate_q;
    if (reg_wr && reg_addr == egress_cfg_pkg::TAG_RULES_ADDR) begin
      tag_rules_d = reg_wdata & egress_cfg_pkg::TAG_RULES_MASK;
    end
    if (reg_wr && rate_index(reg_addr) != 2'h3) begin
      rate_d[2 * rate_index(reg_addr)] =
        reg_wdata[egress_cfg_pkg::RATE_LO_LSB +: RW];
      rate_d[2 * rate_index(reg_addr) + 1] =
        reg_wdata[egress_cfg_pkg::RATE_HI_LSB +: RW];
    end
  end

  // Register reads; unmapped addresses and reserved bits read zero.
  always_comb begin
    reg_rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == egress_cfg_pkg::TAG_RULES_ADDR) begin
        reg_rdata_d = tag_rules_q;
      end else if (rate_index(reg_addr) != 2'h3) begin
        reg_rdata_d = {6'h00, rate_q[2 * rate_index(reg_addr) + 1],
                       rate_q[2 * rate_index(reg_addr)]};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tag_rules_q <= egress_cfg_pkg::TAG_RULES_RESET;
      rate_q <= {egress_cfg_pkg::NUM_QUEUES{egress_cfg_pkg::RATE_RESET}};
      reg_rdata_q <= 32'h0000_0000;
    end else begin
      tag_rules_q <= tag_rules_d;
      rate_q <= rate_d;
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // Each port takes its own byte of the tagging rules word.
  for (genvar p = 0; p < egress_cfg_pkg::NUM_PORTS; p++) begin : g_ctl
    assign cfg.port_ctl[p] =
      tag_rules_q[p * egress_cfg_pkg::PORT_FIELD_W +:
                  egress_cfg_pkg::PORT_FIELD_W];
  end
  assign cfg.rate = rate_q;

  egress_tagger u_tagger (
    .clk(clk),
    .rst_b(rst_b),
    .cfg(cfg.tagger),
    .pkt_valid(pkt_valid),
    .pkt_class(pkt_class),
    .pkt_untag(pkt_untag),
    .act_valid_q(act_valid_q),
    .act_q(act_q)
  );

  egress_shaper u_shaper (
    .clk(clk),
    .rst_b(rst_b),
    .cfg(cfg.shaper),
    .byte_req(byte_req),
    .byte_grant_q(byte_grant_q)
  );

  // Checks.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  logic wr_tag;
  logic [2:0] hyb;
  assign wr_tag = reg_wr && reg_addr == egress_cfg_pkg::TAG_RULES_ADDR;
  for (genvar p = 0; p < egress_cfg_pkg::NUM_PORTS; p++) begin : g_hyb
    assign hyb[p] = cfg.port_ctl[p][1:0] == egress_cfg_pkg::EGR_HYBRID;
  end

  chk_type_fields: assert property (wr_tag |=>
    tag_rules_q[17:16] == $past(reg_wdata[17:16]) &&
    tag_rules_q[9:8] == $past(reg_wdata[9:8]) &&
    tag_rules_q[1:0] == $past(reg_wdata[1:0]))
    else $error("Egress type field not stored.");

  chk_port1_ctl: assert property (wr_tag |=>
    cfg.port_ctl[1][5:2] == $past(reg_wdata[13:10]))
    else $error("Port 1 tag controls not stored.");

  chk_port0_ctl: assert property (wr_tag |=>
    cfg.port_ctl[0][5:2] == $past(reg_wdata[5:2]) &&
    tag_rules_q[7:6] == 2'h0)
    else $error("Port 0 tag controls not stored.");

  chk_dumb_strip: assert property (pkt_valid[0] &&
    cfg.port_ctl[0][1:0] == egress_cfg_pkg::EGR_DUMB |=>
    act_valid_q[0] && act_q[0].strip ==
    ($past(pkt_class[0]) == egress_cfg_pkg::PKT_SPECIAL))
    else $error("Dumb port strip wrong.");

  chk_access_strip: assert property (pkt_valid[1] &&
    cfg.port_ctl[1][1:0] == egress_cfg_pkg::EGR_ACCESS &&
    pkt_class[1] != egress_cfg_pkg::PKT_UNTAGGED |=> act_q[1].strip)
    else $error("Access port kept a tag.");

  chk_cpu_special: assert property (pkt_valid[2] &&
    cfg.port_ctl[2][1:0] == egress_cfg_pkg::EGR_CPU |=>
    act_q[2].add_special && !act_q[2].strip)
    else $error("CPU port did not add special tag.");

  chk_hybrid_insert: assert property (pkt_valid[2] && hyb[2] &&
    pkt_class[2] == egress_cfg_pkg::PKT_UNTAGGED |=>
    act_q[2].insert == $past(cfg.port_ctl[2][5] && !pkt_untag[2]))
    else $error("Hybrid insert wrong.");

  chk_hybrid_vid: assert property (pkt_valid[0] && hyb[0] &&
    !pkt_untag[0] && pkt_class[0] == egress_cfg_pkg::PKT_REGULAR |=>
    act_q[0].chg_vid == $past(cfg.port_ctl[0][4] && cfg.port_ctl[0][2]))
    else $error("Hybrid VLAN ID change wrong.");

  chk_prio_ingress: assert property (pkt_valid[1] && hyb[1] &&
    !pkt_untag[1] && pkt_class[1] == egress_cfg_pkg::PKT_PRIORITY |=>
    act_q[1].vid_ingress && !act_q[1].chg_pri)
    else $error("Priority tagged packet not given ingress ID.");

  chk_hybrid_pri: assert property (pkt_valid[1] && hyb[1] &&
    pkt_class[1] == egress_cfg_pkg::PKT_REGULAR |=>
    act_q[1].chg_pri == $past(cfg.port_ctl[1][3] &&
    cfg.port_ctl[1][2] && !pkt_untag[1]))
    else $error("Hybrid priority change wrong.");

  chk_chg_tag_gate: assert property (pkt_valid[2] &&
    !cfg.port_ctl[2][2] |=> !act_q[2].chg_vid && !act_q[2].chg_pri)
    else $error("Change without change-tag.");

  chk_rate_write: assert property (reg_wr &&
    reg_addr == egress_cfg_pkg::RATE_P0_Q23_ADDR |=>
    rate_q[2] == $past(reg_wdata[12:0]) &&
    rate_q[3] == $past(reg_wdata[25:13]))
    else $error("Rate write to second pair lost.");

  chk_rate_read: assert property (reg_rd &&
    reg_addr == egress_cfg_pkg::RATE_P1_Q01_ADDR |=>
    reg_rdata_q == {6'h00, $past(rate_q[5]), $past(rate_q[4])})
    else $error("Rate read data wrong.");

  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata_q == 32'h0000_0000)
    else $error("Read data outside read cycle.");

  chk_tag_reserved: assert property (wr_tag |=>
    (tag_rules_q & ~egress_cfg_pkg::TAG_RULES_MASK) == 32'h0000_0000)
    else $error("Reserved tag bits stored.");

  chk_port2_ctl: assert property (wr_tag |=>
    cfg.port_ctl[2][5:2] == $past(reg_wdata[21:18]))
    else $error("Port 2 tag controls not stored.");

  chk_tag_hold: assert property (!wr_tag |=> $stable(tag_rules_q))
    else $error("Tag rules changed without a write.");

  chk_tag_read: assert property (reg_rd &&
    reg_addr == egress_cfg_pkg::TAG_RULES_ADDR |=>
    reg_rdata_q == $past(tag_rules_q))
    else $error("Tag rules read data wrong.");

  chk_rate_write_p0: assert property (reg_wr &&
    reg_addr == egress_cfg_pkg::RATE_P0_Q01_ADDR |=>
    rate_q[0] == $past(reg_wdata[12:0]) &&
    rate_q[1] == $past(reg_wdata[25:13]))
    else $error("Rate write to first pair lost.");

  chk_rate_write_p1: assert property (reg_wr &&
    reg_addr == egress_cfg_pkg::RATE_P1_Q01_ADDR |=>
    rate_q[4] == $past(reg_wdata[12:0]) &&
    rate_q[5] == $past(reg_wdata[25:13]))
    else $error("Rate write to third pair lost.");

  chk_rate_hold: assert property (!reg_wr |=> $stable(rate_q))
    else $error("Rate changed without a write.");

  chk_unmapped_write: assert property (reg_wr && !wr_tag &&
    rate_index(reg_addr) == 2'h3 |=> $stable(rate_q))
    else $error("Unmapped write changed a rate.");

  chk_unmapped_read: assert property (reg_rd &&
    reg_addr != egress_cfg_pkg::TAG_RULES_ADDR &&
    rate_index(reg_addr) == 2'h3 |=> reg_rdata_q == 32'h0000_0000)
    else $error("Unmapped read returned data.");

  chk_rate_read_p0: assert property (reg_rd &&
    reg_addr == egress_cfg_pkg::RATE_P0_Q01_ADDR |=>
    reg_rdata_q == {6'h00, $past(rate_q[1]), $past(rate_q[0])})
    else $error("First pair read data wrong.");

  chk_rate_read_q23: assert property (reg_rd &&
    reg_addr == egress_cfg_pkg::RATE_P0_Q23_ADDR |=>
    reg_rdata_q == {6'h00, $past(rate_q[3]), $past(rate_q[2])})
    else $error("Second pair read data wrong.");

  chk_dumb_keep: assert property (pkt_valid[1] &&
    cfg.port_ctl[1][1:0] == egress_cfg_pkg::EGR_DUMB &&
    pkt_class[1] != egress_cfg_pkg::PKT_SPECIAL |=> act_q[1] == '0)
    else $error("Dumb port changed a regular packet.");

  chk_access_untagged: assert property (pkt_valid[0] &&
    cfg.port_ctl[0][1:0] == egress_cfg_pkg::EGR_ACCESS &&
    pkt_class[0] == egress_cfg_pkg::PKT_UNTAGGED |=> act_q[0] == '0)
    else $error("Access port changed an untagged packet.");

  chk_cpu_only: assert property (pkt_valid[0] &&
    cfg.port_ctl[0][1:0] == egress_cfg_pkg::EGR_CPU |=>
    act_q[0].add_special && !act_q[0].strip && !act_q[0].insert &&
    !act_q[0].chg_vid && !act_q[0].chg_pri && !act_q[0].vid_ingress)
    else $error("CPU port action not special tag alone.");

  chk_hybrid_strip: assert property (pkt_valid[0] && hyb[0] &&
    pkt_class[0] != egress_cfg_pkg::PKT_UNTAGGED && (pkt_untag[0] ||
    pkt_class[0] == egress_cfg_pkg::PKT_SPECIAL) |=> act_q[0].strip)
    else $error("Hybrid port kept a tag it must strip.");

  chk_hybrid_ins_p0: assert property (pkt_valid[0] && hyb[0] &&
    pkt_class[0] == egress_cfg_pkg::PKT_UNTAGGED |=>
    act_q[0].insert == $past(cfg.port_ctl[0][5] && !pkt_untag[0]))
    else $error("Port 0 hybrid insert wrong.");

  chk_hybrid_chg_p2: assert property (pkt_valid[2] && hyb[2] &&
    !pkt_untag[2] && pkt_class[2] == egress_cfg_pkg::PKT_REGULAR |=>
    act_q[2].chg_vid == $past(cfg.port_ctl[2][4] && cfg.port_ctl[2][2]))
    else $error("Port 2 VLAN ID change wrong.");

  chk_hybrid_pri_p0: assert property (pkt_valid[0] && hyb[0] &&
    pkt_class[0] == egress_cfg_pkg::PKT_REGULAR |=>
    act_q[0].chg_pri == $past(cfg.port_ctl[0][3] &&
    cfg.port_ctl[0][2] && !pkt_untag[0]))
    else $error("Port 0 priority change wrong.");

  for (genvar p = 0; p < egress_cfg_pkg::NUM_PORTS; p++) begin : g_act
    chk_act_follow: assert property (pkt_valid[p] |=> act_valid_q[p])
      else $error("Tag action missing.");

    chk_act_idle: assert property (!pkt_valid[p] |=>
      !act_valid_q[p] && act_q[p] == '0)
      else $error("Tag action outside a descriptor.");

    chk_plain_types: assert property (pkt_valid[p] && !hyb[p] |=>
      !act_q[p].insert && !act_q[p].chg_vid && !act_q[p].chg_pri)
      else $error("Tag change outside hybrid type.");
  end

  cov_tag_write: cover property (wr_tag ##1 reg_rd &&
    reg_addr == egress_cfg_pkg::TAG_RULES_ADDR);
  cov_hybrid_insert: cover property (act_valid_q[2] && act_q[2].insert);
  cov_cpu_tag: cover property (act_valid_q[0] && act_q[0].add_special);
  cov_paced_bytes: cover property (byte_grant_q[0] ##[1:20] byte_grant_q[0]);
  cov_access_strip: cover property (act_valid_q[1] && act_q[1].strip);
endmodule // egress_tag_rate_config
`default_nettype wire

/* testbench/testbench.sv */
/*
  Self-checking testbench for the egress tagging and rate register bank.
  Assumes the design files under hw/ are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
  n_fail++; $display("wrong value at %0t: got %h expected %h", \
  $time, (got), (exp)); end end
module testbench;
  typedef struct packed {
    logic [5:0] ctl;
    logic [1:0] cls;
    logic untag;
    logic [5:0] exp;
    logic [5:0] exp2;
  } row_s;
  // Port control, packet class, un-tag, action for ports 0/1, port 2.
  row_s rows [15] = '{
    '{6'h00, 2'h3, 1'h0, 6'h20, 6'h20},
    '{6'h00, 2'h1, 1'h0, 6'h00, 6'h00},
    '{6'h01, 2'h1, 1'h0, 6'h20, 6'h20},
    '{6'h01, 2'h0, 1'h0, 6'h00, 6'h00},
    '{6'h01, 2'h3, 1'h0, 6'h20, 6'h20},
    '{6'h03, 2'h0, 1'h0, 6'h01, 6'h01},
    '{6'h22, 2'h0, 1'h0, 6'h10, 6'h00},
    '{6'h22, 2'h0, 1'h1, 6'h00, 6'h00},
    '{6'h1e, 2'h1, 1'h0, 6'h0c, 6'h00},
    '{6'h1a, 2'h1, 1'h0, 6'h00, 6'h00},
    '{6'h16, 2'h1, 1'h0, 6'h08, 6'h00},
    '{6'h0e, 2'h1, 1'h0, 6'h04, 6'h00},
    '{6'h1e, 2'h2, 1'h0, 6'h02, 6'h02},
    '{6'h1e, 2'h1, 1'h1, 6'h20, 6'h20},
    '{6'h1e, 2'h3, 1'h0, 6'h20, 6'h20}
  };
  logic [12:0] rate [6] = '{13'h0000, 13'h0001, 13'h0002, 13'h0005,
    13'h0008, 13'h0014};
  logic clk;
  logic rst_b;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata_q;
  logic [2:0] pkt_valid;
  logic [2:0][1:0] pkt_class;
  logic [2:0] pkt_untag;
  logic [2:0] act_valid_q;
  egress_cfg_pkg::tag_act_s [2:0] act_q;
  logic [5:0] byte_req;
  logic [5:0] byte_grant_q;
  int n_fail = 0;
  int compares = 0;
  int seen [6];
  int last [6];
  int gap [6];
  row_s r;

  egress_tag_rate_config dut (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .pkt_valid(pkt_valid), .pkt_class(pkt_class), .pkt_untag(pkt_untag),
    .act_valid_q(act_valid_q), .act_q(act_q), .byte_req(byte_req),
    .byte_grant_q(byte_grant_q)
  );

  initial clk = 1'b0;
  always #20 clk = ~clk;

  task automatic complete_run();
    if (n_fail == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata_q, e)
  endtask

  initial begin
    #2000000;
    n_fail++;
    complete_run();
  end

  initial begin
    rst_b = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pkt_valid = 3'h0;
    pkt_class = 6'h00;
    pkt_untag = 3'h0;
    byte_req = 6'h00;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, including one unmapped index.
    for (int a = 16'h1c0c; a <= 16'h1c10; a++) begin
      rd(16'(a), 32'h0000_0000);
    end
    wr(16'h1c0c, 32'hffff_ffff);
    rd(16'h1c0c, 32'h003f_3f3f);
    wr(16'h1c0f, 32'hffff_ffff);
    rd(16'h1c0f, 32'h03ff_ffff);
    wr(16'h1c10, 32'hffff_ffff);
    rd(16'h1c10, 32'h0000_0000);
    rd(16'h1c0e, 32'h0000_0000);
    // Write followed at once by a read, then read data drop to zero.
    @(posedge clk);
    reg_addr <= 16'h1c0e;
    reg_wdata <= 32'hfd23_4567;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata_q, 32'h0123_4567)
    @(posedge clk);
    #1;
    `CHK(reg_rdata_q, 32'h0000_0000)
    // Tag decisions for every egress type on all three ports.
    for (int i = 0; i < 15; i++) begin
      r = rows[i];
      wr(16'h1c0c, {14'h0000, r.ctl[1:0], 2'h0, r.ctl, 2'h0, r.ctl});
      rd(16'h1c0c, {14'h0000, r.ctl[1:0], 2'h0, r.ctl, 2'h0, r.ctl});
      @(posedge clk);
      pkt_valid <= 3'h7;
      pkt_class <= {3{r.cls}};
      pkt_untag <= {3{r.untag}};
      @(posedge clk);
      pkt_valid <= 3'h0;
      #1;
      `CHK(act_valid_q, 3'h7)
      `CHK(act_q[0], r.exp)
      `CHK(act_q[1], r.exp)
      `CHK(act_q[2], r.exp2)
      @(posedge clk);
      #1;
      `CHK(act_valid_q, 3'h0)
    end
    // Port 2 hybrid insert, written and read back with no gap.
    @(posedge clk);
    reg_addr <= 16'h1c0c;
    reg_wdata <= 32'hffe2_0000;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    pkt_valid <= 3'h4;
    pkt_class <= 6'h00;
    pkt_untag <= 3'h0;
    @(posedge clk);
    reg_rd <= 1'b0;
    pkt_valid <= 3'h0;
    #1;
    `CHK(reg_rdata_q, 32'h0022_0000)
    `CHK(act_valid_q, 3'h4)
    `CHK(act_q[2], 6'h10)
    // Byte pacing per queue.
    wr(16'h1c0d, {6'h00, rate[1], rate[0]});
    wr(16'h1c0e, {6'h00, rate[3], rate[2]});
    wr(16'h1c0f, {6'h00, rate[5], rate[4]});
    rd(16'h1c0f, {6'h00, rate[5], rate[4]});
    for (int q = 0; q < 6; q++) begin
      seen[q] = 0;
      last[q] = 0;
      gap[q] = 0;
    end
    @(posedge clk);
    byte_req <= 6'h3f;
    for (int c = 0; c < 150; c++) begin
      @(posedge clk);
      #1;
      for (int q = 0; q < 6; q++) begin
        if (byte_grant_q[q] === 1'b1) begin
          seen[q]++;
          if (seen[q] >= 2) begin
            gap[q] = c - last[q];
          end
          last[q] = c;
        end
      end
    end
    for (int q = 0; q < 6; q++) begin
      `CHK(gap[q], (int'(rate[q]) + 2) / 2 + 1)
    end
    @(posedge clk);
    byte_req <= 6'h00;
    repeat (2) @(posedge clk);
    for (int c = 0; c < 10; c++) begin
      @(posedge clk);
      #1;
      `CHK(byte_grant_q, 6'h00)
    end
    // Reset in mid-run clears the bank.
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK(byte_grant_q, 6'h00)
    `CHK(reg_rdata_q, 32'h0000_0000)
    @(posedge clk);
    rst_b <= 1'b1;
    rd(16'h1c0d, 32'h0000_0000);
    rd(16'h1c0c, 32'h0000_0000);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
